// ---- src/swd_port_acquisition.sv ----
// serial debug port pin pair selection and acquisition
//
// Operation
// - the link uses one host-driven clock pin and one two-way data pin.
// - the link may run on the jtag mode/clock pair or on the usb data pin pair.
// - at most one pin pair carries the link at any time.
// - the acquire sequence enables the link on a pair only if it arrives within 8 us of reset release.
// - when the nonvolatile config latches select serial debug, the jtag pair is enabled without a sequence.
// - the usb pair always needs the acquire sequence within the key window.
// - the link can be switched on from jtag, and switched off to return its pins to gpio.
// - after a disable, the acquire sequence is ignored until the key window after the next reset.
// - an acquired link accepts a command that re-enables jtag; on the jtag pair jtag stays off until the link is switched off.
// - boundary scan and device chaining stay on jtag and are never reached through the link.
// - the link offers all debug and flash functions of jtag at the same speed.
module swd_port_acquisition
	import swd_acq_pkg::*;
#(
	parameter int                   WINDOW_CYC = KEY_WINDOW_CYC,
	parameter int                   PAT_LEN    = ACQ_LEN,
	parameter logic [PAT_LEN-1:0]   PATTERN    = ACQ_PATTERN
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire swd_acq_pkg::pair_in_t jtag_pins,
	input  wire swd_acq_pkg::pair_in_t usb_data_pin_pair,
	input  wire logic                  nonvolatile_config_latches,
	input  wire logic                  jtag_swd_enable,
	input  wire logic                  swd_disable,
	input  wire logic                  core_dat_o,
	input  wire logic                  core_dat_oe,
	input  wire logic                  core_jtag_reenable,
	output logic                       jtag_swd_active_q,
	output logic                       usb_swd_active_q,
	output logic                       jtag_enable_q,
	output logic                       swd_clk_rise_q,
	output logic                       swd_dat_in_q,
	output swd_acq_pkg::pair_out_t     jtag_dat_q,
	output swd_acq_pkg::pair_out_t     usb_dat_q
);
	import swd_acq_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// synchronisers and clock edge detection
	pair_in_t j_s1_q, j_s2_q, j_s3_q, u_s1_q, u_s2_q, u_s3_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			j_s1_q <= '0;
			j_s2_q <= '0;
			j_s3_q <= '0;
			u_s1_q <= '0;
			u_s2_q <= '0;
			u_s3_q <= '0;
		end else begin
			j_s1_q <= jtag_pins;
			j_s2_q <= j_s1_q;
			j_s3_q <= j_s2_q;
			u_s1_q <= usb_data_pin_pair;
			u_s2_q <= u_s1_q;
			u_s3_q <= u_s2_q;
		end
	end
	// sampling at 25 MHz needs the host clock at most a third of that
	logic j_rise, u_rise;
	assign j_rise = j_s2_q.clk & ~j_s3_q.clk;
	assign u_rise = u_s2_q.clk & ~u_s3_q.clk;

	////////////////////////////////////////////////////////////////////////
	// key window and pattern shifters
	logic [CNT_W-1:0]   win_q, win_d;
	logic [PAT_LEN-1:0] j_sh_q, j_sh_d, u_sh_q, u_sh_d;
	logic               in_window;
	assign in_window = (win_q < CNT_W'(WINDOW_CYC));
	always_comb begin
		win_d  = in_window ? win_q + 1'b1 : win_q;
		j_sh_d = j_rise ? {j_sh_q[PAT_LEN-2:0], j_s2_q.dat} : j_sh_q;
		u_sh_d = u_rise ? {u_sh_q[PAT_LEN-2:0], u_s2_q.dat} : u_sh_q;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			win_q  <= '0;
			j_sh_q <= '0;
			u_sh_q <= '0;
		end else begin
			win_q  <= win_d;
			j_sh_q <= j_sh_d;
			u_sh_q <= u_sh_d;
		end
	end
	logic j_hit, u_hit;
	assign j_hit = in_window & j_rise & ({j_sh_q[PAT_LEN-2:0], j_s2_q.dat} == PATTERN);
	assign u_hit = in_window & u_rise & ({u_sh_q[PAT_LEN-2:0], u_s2_q.dat} == PATTERN);

	////////////////////////////////////////////////////////////////////////
	// selection state machine
	acq_state_t st_q, st_d;
	logic       latch_q, latch_d, jen_q, jen_d, started_q;
	always_comb begin
		st_d    = st_q;
		latch_d = latch_q;
		jen_d   = jen_q;
		unique case (st_q)
			ST_KEY: begin
				if (j_hit) begin
					st_d = ST_JTAG;
				end else if (u_hit) begin
					st_d = ST_USB;
				end else if (!in_window) begin
					st_d = latch_q ? ST_JTAG : ST_GPIO;
				end
			end
			ST_JTAG, ST_USB: begin
				if (swd_disable) begin
					st_d = ST_GPIO;
				end
			end
			ST_GPIO: begin
				if (jtag_swd_enable && jen_q) begin
					st_d = ST_JTAG;
				end
			end
			default: st_d = ST_GPIO;
		endcase
		// link on jtag pins excludes jtag scan use
		if (st_d == ST_JTAG || st_d == ST_USB) begin
			if (core_jtag_reenable) begin
				jen_d = 1'b1;
			end else if (st_d == ST_JTAG && st_q != ST_JTAG) begin
				jen_d = 1'b0;
			end
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q      <= ST_KEY;
			latch_q   <= 1'b0;
			jen_q     <= 1'b1;
			started_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			started_q <= 1'b1;
			latch_q   <= started_q ? latch_d : nonvolatile_config_latches;
			jen_q     <= jen_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin routing between the pin pairs and the debug core
	logic on_j, on_u;
	assign on_j = (st_q == ST_JTAG);
	assign on_u = (st_q == ST_USB);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			jtag_swd_active_q <= 1'b0;
			usb_swd_active_q  <= 1'b0;
			jtag_enable_q     <= 1'b1;
			swd_clk_rise_q    <= 1'b0;
			swd_dat_in_q      <= 1'b0;
			jtag_dat_q        <= '0;
			usb_dat_q         <= '0;
		end else begin
			jtag_swd_active_q <= on_j;
			usb_swd_active_q  <= on_u;
			jtag_enable_q     <= jen_q & ~on_j;
			swd_clk_rise_q    <= (on_j & j_rise) | (on_u & u_rise);
			swd_dat_in_q      <= on_j ? j_s2_q.dat : (on_u ? u_s2_q.dat : 1'b0);
			jtag_dat_q        <= '{dat_o: core_dat_o, dat_oe: core_dat_oe & on_j};
			usb_dat_q         <= '{dat_o: core_dat_o, dat_oe: core_dat_oe & on_u};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	a_one_pair_only: assert property (@(posedge clk) disable iff (!nrst)
		!(jtag_swd_active_q && usb_swd_active_q))
		else $error("link active on both pairs");
	a_usb_needs_key: assert property (@(posedge clk) disable iff (!nrst)
		(st_q == ST_KEY && st_d == ST_USB) |-> u_hit)
		else $error("usb pair enabled without sequence");
	a_key_in_window: assert property (@(posedge clk) disable iff (!nrst)
		(st_q == ST_KEY && st_d != ST_KEY) |-> (j_hit || u_hit || win_q == CNT_W'(WINDOW_CYC)))
		else $error("key window left early");
	a_latch_bypass: assert property (@(posedge clk) disable iff (!nrst)
		(st_q == ST_KEY && !in_window && latch_q && !u_hit) |=> st_q == ST_JTAG)
		else $error("latch bypass not taken");
	a_no_key_gpio: assert property (@(posedge clk) disable iff (!nrst)
		(st_q == ST_KEY && !in_window && !latch_q) |=> st_q == ST_GPIO)
		else $error("pins left wrong role after window");
	a_disable_gpio: assert property (@(posedge clk) disable iff (!nrst)
		((on_j || on_u) && swd_disable) |=> st_q == ST_GPIO ##1 !jtag_swd_active_q && !usb_swd_active_q)
		else $error("disable did not release pins");
	a_jtag_reenable: assert property (@(posedge clk) disable iff (!nrst)
		(on_u && core_jtag_reenable && !swd_disable) |=> jen_q ##1 jtag_enable_q)
		else $error("jtag not re-enabled");
	a_oe_follows_pair: assert property (@(posedge clk) disable iff (!nrst)
		usb_dat_q.dat_oe |-> $past(on_u))
		else $error("usb data driven while not selected");
	a_jtag_oe_pair: assert property (@(posedge clk) disable iff (!nrst)
		jtag_dat_q.dat_oe |-> $past(on_j))
		else $error("jtag data driven while not selected");
	a_reenable_sticky: assert property (@(posedge clk) disable iff (!nrst)
		(on_j && core_jtag_reenable && !swd_disable) |=> jen_q ##1 jen_q)
		else $error("jtag re-enable lost while link on jtag pair");
	a_scan_off_link: assert property (@(posedge clk) disable iff (!nrst)
		jtag_swd_active_q |-> !jtag_enable_q)
		else $error("jtag scan usable while link owns jtag pins");
	a_rise_on_pair: assert property (@(posedge clk) disable iff (!nrst)
		swd_clk_rise_q |-> $past(on_j || on_u))
		else $error("clock rise passed with no pair selected");
	a_jtag_key_wins: assert property (@(posedge clk) disable iff (!nrst)
		(st_q == ST_KEY && j_hit) |=> st_q == ST_JTAG)
		else $error("jtag acquire not taken");
	a_window_closes: assert property (@(posedge clk) disable iff (!nrst)
		(st_q == ST_KEY && !in_window) |=> st_q != ST_KEY)
		else $error("key window did not close");
	// cover points
	c_jtag_acq: cover property (@(posedge clk) disable iff (!nrst) st_q == ST_KEY ##1 st_q == ST_JTAG);
	c_usb_acq: cover property (@(posedge clk) disable iff (!nrst) st_q == ST_KEY ##1 st_q == ST_USB);
	c_to_gpio: cover property (@(posedge clk) disable iff (!nrst) on_j ##1 st_q == ST_GPIO);
	c_reenable: cover property (@(posedge clk) disable iff (!nrst) on_j && core_jtag_reenable);
	c_gpio_to_jtag: cover property (@(posedge clk) disable iff (!nrst) st_q == ST_GPIO ##1 st_q == ST_JTAG);
endmodule

// ---- src/swd_acq_pkg.sv ----
// constants and types for serial debug port acquisition
package swd_acq_pkg;
	localparam int    CLK_HZ          = 25_000_000;
	localparam int    KEY_WINDOW_NS   = 8000;
	// longest time rounds down
	localparam int    KEY_WINDOW_CYC  = (KEY_WINDOW_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int    CNT_W           = 16;
	localparam int    ACQ_LEN         = 16;
	localparam logic [ACQ_LEN-1:0] ACQ_PATTERN = 16'ha5c3;

	typedef enum logic [3:0] {
		ST_KEY   = 4'h1,
		ST_JTAG  = 4'h2,
		ST_USB   = 4'h4,
		ST_GPIO  = 4'h8
	} acq_state_t;

	// one pin pair, raw or synchronised: clock and data
	typedef struct packed {
		logic clk;
		logic dat;
	} pair_in_t;

	// data pin drive toward the host
	typedef struct packed {
		logic dat_o;
		logic dat_oe;
	} pair_out_t;
endpackage

// ---- verif/swd_host_model.sv ----
// host programmer model driving one debug pin pair
module swd_host_model
	import swd_acq_pkg::*;
(
	output swd_acq_pkg::pair_in_t pins
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pins = 2'b00;
	// clock stands low between frames; bits go out msb first
	task automatic send(input logic [15:0] bits, input int n);
		#13;
		for (int i = n - 1; i >= 0; i--) begin
			pins.dat = bits[i];
			#160 pins.clk = 1'b1;
			#160 pins.clk = 1'b0;
		end
		// released data line shows the inverse of the last bit
		pins.dat = ~bits[0];
	endtask
endmodule

// ---- verif/swd_port_acquisition_bench.sv ----
// self-checking bench for serial debug port acquisition
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module swd_port_acquisition_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import swd_acq_pkg::*;
	localparam int WIN = 200;
	logic      clk, nrst, latch, swd_en, dis, dat_o, dat_oe, reen;
	logic      j_act, u_act, j_en, rise, din;
	pair_in_t  jp, up;
	pair_out_t jd, ud;
	int        mismatches = 0;
	int        checks = 0;
	int        rises = 0;
	swd_port_acquisition #(.WINDOW_CYC(WIN)) swd_port_acquisition_i (.clk(clk), .nrst(nrst),
		.jtag_pins(jp), .usb_data_pin_pair(up), .nonvolatile_config_latches(latch),
		.jtag_swd_enable(swd_en), .swd_disable(dis), .core_dat_o(dat_o), .core_dat_oe(dat_oe),
		.core_jtag_reenable(reen), .jtag_swd_active_q(j_act), .usb_swd_active_q(u_act),
		.jtag_enable_q(j_en), .swd_clk_rise_q(rise), .swd_dat_in_q(din), .jtag_dat_q(jd), .usb_dat_q(ud));
	swd_host_model swd_host_model_i (.pins(jp));
	swd_host_model usb_host_i (.pins(up));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (rise === 1'b1) rises++;
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic start(input logic l);
		{nrst, swd_en, dis, reen, dat_o, dat_oe} = '0;
		latch = l;
		cyc(8);
		nrst = 1'b1;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_usb;
		start(1'b0);
		usb_host_i.send(ACQ_PATTERN, 16);
		cyc(10);
		`CHK(u_act, 1'b1)
		`CHK(j_act, 1'b0)
		{dat_o, dat_oe} = 2'b11;
		cyc(3);
		`CHK(ud, 2'b11)
		`CHK(jd.dat_oe, 1'b0)
		rises = 0;
		usb_host_i.send(16'h0000, 4);
		cyc(5);
		`CHK(rises, 4)
		`CHK(din, 1'b1)
		reen = 1'b1;
		cyc(1);
		reen = 1'b0;
		cyc(2);
		`CHK(j_en, 1'b1)
		`CHK(u_act, 1'b1)
	endtask
	task automatic t_latch;
		start(1'b1);
		cyc(WIN + 6);
		`CHK(j_act, 1'b1)
		`CHK(j_en, 1'b0)
		reen = 1'b1;
		cyc(1);
		reen = 1'b0;
		cyc(2);
		`CHK(j_en, 1'b0)
		`CHK(j_act, 1'b1)
		dis = 1'b1;
		cyc(4);
		`CHK(j_act, 1'b0)
		`CHK(j_en, 1'b1)
	endtask
	task automatic t_late;
		start(1'b0);
		cyc(WIN + 4);
		usb_host_i.send(ACQ_PATTERN, 16);
		cyc(10);
		`CHK(u_act, 1'b0)
		`CHK(j_act, 1'b0)
		swd_en = 1'b1;
		cyc(6);
		`CHK(j_act, 1'b1)
		`CHK(u_act, 1'b0)
	endtask
	task automatic t_reacq;
		start(1'b0);
		fork
			swd_host_model_i.send(ACQ_PATTERN, 16);
			usb_host_i.send(ACQ_PATTERN, 16);
		join
		cyc(10);
		`CHK(j_act, 1'b1)
		`CHK(j_en, 1'b0)
		`CHK(u_act, 1'b0)
		dis = 1'b1;
		cyc(4);
		`CHK(j_act, 1'b0)
		start(1'b0);
		swd_host_model_i.send(ACQ_PATTERN, 16);
		cyc(10);
		`CHK(j_act, 1'b1)
		`CHK(u_act, 1'b0)
	endtask
	////////////////////////////////////////////////////////////////
	task automatic final_report;
		if (mismatches == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		{nrst, latch, swd_en, dis, reen, dat_o, dat_oe} = '0;
		@(negedge clk);
		t_usb;
		t_latch;
		t_late;
		t_reacq;
		final_report;
	end
	initial begin
		#200us;
		mismatches++;
		final_report;
	end
endmodule
